// ===== rtl/cts_supervisor.sv
// Purpose: Current transformer wiring supervision with definite-time alarm
// Assumes: cycle_stb marks each program cycle and never comes two clocks in a row
// Notes: Blocking pin is synchronised; all other inputs are on clk_sys
`timescale 1ns/1ps
module cts_supervisor #(
  parameter int CUR_W = cts_pkg::CUR_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic cycle_stb,
  input wire logic block_pin,
  input wire logic [CUR_W-1:0] i_l1,
  input wire logic [CUR_W-1:0] i_l2,
  input wire logic [CUR_W-1:0] i_l3,
  input wire logic [CUR_W-1:0] i_res_calc,
  input wire logic [CUR_W-1:0] i_res_meas,
  input wire logic [CUR_W-1:0] i_pos_seq,
  input wire logic [CUR_W-1:0] i_neg_seq,
  input wire logic [CUR_W-1:0] upper_phase_current_limit,
  input wire logic [CUR_W-1:0] lower_phase_current_limit,
  input wire logic [CUR_W-1:0] residual_diff_limit,
  input wire logic [cts_pkg::PCT_W-1:0] min_max_current_ratio_limit,
  input wire logic [cts_pkg::PCT_W-1:0] neg_pos_sequence_ratio_limit,
  input wire logic residual_input_select,
  input wire logic [cts_pkg::TMR_W-1:0] alarm_delay_cycles,
  input wire logic [3:0] event_store_sel,
  input wire logic [cts_pkg::TS_W-1:0] time_stamp,
  input wire logic [cts_pkg::SG_W-1:0] setting_group,
  input wire logic [cts_pkg::IDX_W-1:0] log_rd_idx,
  output logic alarm_ff,
  output logic blocked_ff,
  output logic start_ff,
  output logic event_valid_ff,
  output logic [1:0] event_code_ff,
  output logic [cts_pkg::REC_W-1:0] event_rec_ff,
  output logic [cts_pkg::REC_W-1:0] log_rec_ff,
  output logic [cts_pkg::IDX_W-1:0] log_count_ff
);
  typedef struct packed {
    logic blk_s1;
    logic blk_s2;
    logic alarm;
    logic blocked;
    logic start;
    logic [cts_pkg::TMR_W-1:0] timer;
    logic pend;
    logic [cts_pkg::REC_W-1:0] pend_rec;
    logic ev_valid;
    logic [1:0] ev_code;
    logic [cts_pkg::REC_W-1:0] ev_rec;
    logic log_we;
  } cts_st_t;

  cts_st_t st_ff;
  cts_st_t nxt_st;

  // a * full < lim * b, both sides widened so no product is cut
  function automatic logic ratio_below(input logic [CUR_W-1:0] a, input logic [CUR_W-1:0] b,
                                       input logic [cts_pkg::PCT_W-1:0] lim);
    logic [CUR_W+cts_pkg::PCT_W-1:0] lhs;
    logic [CUR_W+cts_pkg::PCT_W-1:0] rhs;
    lhs = a * cts_pkg::PCT_FULL;
    rhs = b * lim;
    return lhs < rhs;
  endfunction

  logic [CUR_W-1:0] i_max;
  logic [CUR_W-1:0] i_min;
  logic [CUR_W-1:0] res_diff;
  logic any_high;
  logic all_low;
  logic ratio_ok;
  logic unbal_ok;
  logic res_ok;
  logic pick;
  logic [cts_pkg::FLT_W-1:0] fault_code;
  logic [cts_pkg::TMR_W-1:0] timer_inc;
  logic [cts_pkg::TMR_W-1:0] remain;

  // Magnitude comparators, evaluated continuously, used on the strobe
  always_comb begin
    i_max = (i_l1 > i_l2) ? i_l1 : i_l2;
    i_max = (i_l3 > i_max) ? i_l3 : i_max;
    i_min = (i_l1 < i_l2) ? i_l1 : i_l2;
    i_min = (i_l3 < i_min) ? i_l3 : i_min;
    res_diff = (i_res_calc > i_res_meas) ? i_res_calc - i_res_meas : i_res_meas - i_res_calc;
    any_high = i_max > upper_phase_current_limit;
    all_low = i_max < lower_phase_current_limit;
    ratio_ok = ratio_below(i_min, i_max, min_max_current_ratio_limit);
    unbal_ok = !ratio_below(i_neg_seq, i_pos_seq, neg_pos_sequence_ratio_limit);
    res_ok = !residual_input_select || (res_diff >= residual_diff_limit);
    pick = !any_high && !all_low && ratio_ok && unbal_ok && res_ok;
    fault_code = {res_ok, unbal_ok, ratio_ok, !all_low, !any_high};
  end

  // Remaining time is zero once the timer has reached the delay
  always_comb begin
    timer_inc = (st_ff.timer == {cts_pkg::TMR_W{1'b1}}) ? st_ff.timer : st_ff.timer + 20'h0_0001;
    remain = (alarm_delay_cycles > st_ff.timer) ? alarm_delay_cycles - st_ff.timer : '0;
  end

  // Record shared by event output and log: stamp, code, remaining, fault, group, currents
  function automatic logic [cts_pkg::REC_W-1:0] make_rec(input logic [1:0] code);
    return {time_stamp, code, remain, fault_code, setting_group, i_neg_seq, i_pos_seq,
            i_res_meas, i_res_calc, i_l3, i_l2, i_l1};
  endfunction

  // Pick-up, block, timer and event sequencing
  always_comb begin
    nxt_st = st_ff;
    nxt_st.blk_s1 = block_pin;
    nxt_st.blk_s2 = st_ff.blk_s1;
    nxt_st.ev_valid = 1'b0;
    nxt_st.log_we = 1'b0;
    // A block change that met an alarm change goes out one clock later
    if (st_ff.pend) begin
      nxt_st.pend = 1'b0;
      nxt_st.ev_rec = st_ff.pend_rec;
      nxt_st.ev_code = st_ff.pend_rec[cts_pkg::REC_EV_LSB +: 2];
      nxt_st.ev_valid = event_store_sel[st_ff.pend_rec[cts_pkg::REC_EV_LSB +: 2]];
      nxt_st.log_we = 1'b1;
    end
    if (cycle_stb) begin
      nxt_st.blocked = pick && st_ff.blk_s2;
      nxt_st.start = pick && !st_ff.blk_s2;
      if (nxt_st.start) begin
        nxt_st.timer = timer_inc;
        nxt_st.alarm = st_ff.alarm || (timer_inc >= alarm_delay_cycles);
      end else begin
        nxt_st.timer = cts_pkg::TMR_RST;
        nxt_st.alarm = 1'b0;
      end
      if (nxt_st.alarm != st_ff.alarm) begin
        nxt_st.ev_code = nxt_st.alarm ? cts_pkg::CTS_EV_ALARM_ON : cts_pkg::CTS_EV_ALARM_OFF;
        nxt_st.ev_rec = make_rec(nxt_st.ev_code);
        nxt_st.ev_valid = event_store_sel[nxt_st.ev_code];
        nxt_st.log_we = 1'b1;
      end
      if (nxt_st.blocked != st_ff.blocked) begin
        if (nxt_st.alarm != st_ff.alarm) begin
          nxt_st.pend = 1'b1;
          nxt_st.pend_rec = make_rec(nxt_st.blocked ? cts_pkg::CTS_EV_BLOCK_ON
                                                    : cts_pkg::CTS_EV_BLOCK_OFF);
        end else begin
          nxt_st.ev_code = nxt_st.blocked ? cts_pkg::CTS_EV_BLOCK_ON : cts_pkg::CTS_EV_BLOCK_OFF;
          nxt_st.ev_rec = make_rec(nxt_st.ev_code);
          nxt_st.ev_valid = event_store_sel[nxt_st.ev_code];
          nxt_st.log_we = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  // Log is written from the registered event, so it trails the event by a clock
  cts_log_store #(
    .DEPTH(cts_pkg::LOG_DEPTH),
    .W(cts_pkg::REC_W)
  ) u_log (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .wr_en(st_ff.log_we),
    .wr_rec(st_ff.ev_rec),
    .rd_idx(log_rd_idx),
    .rd_rec_ff(log_rec_ff),
    .count_ff(log_count_ff)
  );

  assign alarm_ff = st_ff.alarm;
  assign blocked_ff = st_ff.blocked;
  assign start_ff = st_ff.start;
  assign event_valid_ff = st_ff.ev_valid;
  assign event_code_ff = st_ff.ev_code;
  assign event_rec_ff = st_ff.ev_rec;

  // Checks
  sequence s_eval;
    clk_en && cycle_stb;
  endsequence
  // Write strobe stands with the changed alarm; the count shows it a clock later
  sequence s_log_after;
    st_ff.log_we ##1 (log_count_ff != '0);
  endsequence

  property p_high_inhibit;
    @(posedge clk_sys) disable iff (!rst_n) s_eval ##0 any_high |=> !start_ff && !blocked_ff;
  endproperty
  a_high_inhibit: assert property (p_high_inhibit) else $error("start despite high current");
  property p_low_inhibit;
    @(posedge clk_sys) disable iff (!rst_n) s_eval ##0 all_low |=> !start_ff && !alarm_ff;
  endproperty
  a_low_inhibit: assert property (p_low_inhibit) else $error("start despite low currents");
  property p_res_inhibit;
    @(posedge clk_sys) disable iff (!rst_n)
      s_eval ##0 (residual_input_select && res_diff < residual_diff_limit) |=> !start_ff;
  endproperty
  a_res_inhibit: assert property (p_res_inhibit) else $error("start with small residual diff");
  property p_block_wins;
    @(posedge clk_sys) disable iff (!rst_n) s_eval ##0 (pick && st_ff.blk_s2) |=>
      blocked_ff && !start_ff && st_ff.timer == cts_pkg::TMR_RST;
  endproperty
  a_block_wins: assert property (p_block_wins) else $error("blocked pick-up still started");
  property p_early_reset;
    @(posedge clk_sys) disable iff (!rst_n) s_eval ##0 !pick |=> !alarm_ff && st_ff.timer == '0;
  endproperty
  a_early_reset: assert property (p_early_reset) else $error("timer or alarm kept");
  property p_alarm_time;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(alarm_ff) |-> st_ff.timer >= alarm_delay_cycles && $past(pick) && start_ff;
  endproperty
  a_alarm_time: assert property (p_alarm_time) else $error("alarm before delay");
  property p_change_logged;
    @(posedge clk_sys) disable iff (!rst_n) (clk_en && $changed(alarm_ff)) |-> s_log_after;
  endproperty
  a_change_logged: assert property (p_change_logged) else $error("alarm change not logged");
  property p_store_sel;
    @(posedge clk_sys) disable iff (!rst_n) event_valid_ff |-> $past(event_store_sel[nxt_st.ev_code]);
  endproperty
  a_store_sel: assert property (p_store_sel) else $error("unselected event stored");
  property p_stamp;
    @(posedge clk_sys) disable iff (!rst_n) (clk_en && $changed(blocked_ff) && !st_ff.pend) |->
      event_rec_ff[cts_pkg::REC_TS_LSB +: cts_pkg::TS_W] == $past(time_stamp);
  endproperty
  a_stamp: assert property (p_stamp) else $error("event time stamp wrong");
endmodule

// ===== rtl/cts_pkg.sv
// Purpose: Shared constants and types of the CT wiring supervision block
// Assumes: Currents in 0.01 xIn steps, ratios in 0.01 % steps
// Notes: Log record layout is shared by the main module and the log store
package cts_pkg;
  // Widths and sizes
  localparam int CUR_W = 16;
  localparam int PCT_W = 14;
  localparam int TMR_W = 20;
  localparam int TS_W = 32;
  localparam int SG_W = 3;
  localparam int LOG_DEPTH = 12;
  localparam int IDX_W = 4;
  localparam int FLT_W = 5;
  localparam int NCUR = 7;
  // Full scale of a percentage setting (100.00 %)
  localparam logic [PCT_W-1:0] PCT_FULL = 14'h2710;
  // Clock and the lead that the blocking source must keep
  localparam int CLK_PERIOD_NS = 8;
  localparam int BLOCK_LEAD_MS = 5;
  localparam int BLOCK_LEAD_CYC = BLOCK_LEAD_MS * 1000000 / CLK_PERIOD_NS;
  // Reset values
  localparam logic [TMR_W-1:0] TMR_RST = 20'h0_0000;
  localparam logic [IDX_W-1:0] IDX_RST = 4'h0;
  // Event codes: bit 1 picks block/alarm, bit 0 is the on edge
  typedef enum logic [1:0] {
    CTS_EV_ALARM_OFF = 2'h0,
    CTS_EV_ALARM_ON = 2'h1,
    CTS_EV_BLOCK_OFF = 2'h2,
    CTS_EV_BLOCK_ON = 2'h3
  } cts_ev_t;
  // Log record field positions, low to high
  localparam int REC_CUR_LSB = 0;
  localparam int REC_SG_LSB = NCUR * CUR_W;
  localparam int REC_FLT_LSB = REC_SG_LSB + SG_W;
  localparam int REC_TMR_LSB = REC_FLT_LSB + FLT_W;
  localparam int REC_EV_LSB = REC_TMR_LSB + TMR_W;
  localparam int REC_TS_LSB = REC_EV_LSB + 2;
  localparam int REC_W = REC_TS_LSB + TS_W;
endpackage

// ===== rtl/cts_log_store.sv
// Purpose: Rolling store of the most recent supervision log records
// Assumes: One write per clock at most; read index counts back from newest
// Notes: Oldest record is overwritten once the store is full
`timescale 1ns/1ps
module cts_log_store #(
  parameter int DEPTH = cts_pkg::LOG_DEPTH,
  parameter int W = cts_pkg::REC_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_rec,
  input wire logic [cts_pkg::IDX_W-1:0] rd_idx,
  output logic [W-1:0] rd_rec_ff,
  output logic [cts_pkg::IDX_W-1:0] count_ff
);
  typedef struct packed {
    logic [cts_pkg::IDX_W-1:0] wptr;
    logic [cts_pkg::IDX_W-1:0] cnt;
    logic [W-1:0] rd;
  } cts_log_st_t;

  cts_log_st_t st_ff;
  cts_log_st_t nxt_st;
  logic [W-1:0] mem_ff [DEPTH];
  logic [cts_pkg::IDX_W-1:0] slot;

  // Newest record sits one below the write pointer
  always_comb begin
    nxt_st = st_ff;
    slot = (st_ff.wptr > rd_idx) ? st_ff.wptr - rd_idx - 4'h1
                                 : st_ff.wptr + 4'(DEPTH) - rd_idx - 4'h1;
    nxt_st.rd = (rd_idx < st_ff.cnt) ? mem_ff[slot] : '0;
    if (wr_en) begin
      nxt_st.wptr = (st_ff.wptr == 4'(DEPTH - 1)) ? cts_pkg::IDX_RST : st_ff.wptr + 4'h1;
      if (st_ff.cnt != 4'(DEPTH)) begin
        nxt_st.cnt = st_ff.cnt + 4'h1;
      end
    end
  end

  // Memory has no reset; only counted slots are ever shown
  always_ff @(posedge clk_sys) begin
    if (clk_en && wr_en) begin
      mem_ff[st_ff.wptr] <= wr_rec;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign rd_rec_ff = st_ff.rd;
  assign count_ff = st_ff.cnt;

  property p_log_cap;
    @(posedge clk_sys) disable iff (!rst_n) st_ff.cnt <= 4'(DEPTH);
  endproperty
  a_log_cap: assert property (p_log_cap) else $error("log count above depth");
endmodule

// ===== tb/cts_tb.sv
// Purpose: Self-checking bench of the CT wiring supervision block
// Assumes: Limits 1.20 and 0.10 xIn, ratio 10 %, unbalance 49 %, residual 0.10 xIn
// Notes: Inputs move 1 ns after the rising edge; outputs are read at that point too
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    logic [15:0] l1, l2, l3, pos, neg, calc, meas;
    logic sel, pick;
  } cts_tb_row_t;
  // Ordinary pick-up cases, pick is the expected start level
  cts_tb_row_t rows [7] = '{
    '{16'h0064,16'h0064,16'h0064,16'h0064,16'h0000,16'h0000,16'h0000,1'b0,1'b0},
    '{16'h0000,16'h0064,16'h0064,16'h0043,16'h0021,16'h0000,16'h0000,1'b0,1'b1},
    '{16'h0000,16'h0064,16'h0064,16'h0043,16'h0020,16'h0000,16'h0000,1'b0,1'b0},
    '{16'h0005,16'h0096,16'h0064,16'h0055,16'h002b,16'h0000,16'h0000,1'b0,1'b0},
    '{16'h0000,16'h0005,16'h0005,16'h0003,16'h0002,16'h0000,16'h0000,1'b0,1'b0},
    '{16'h0000,16'h0064,16'h0064,16'h0043,16'h0021,16'h0064,16'h0064,1'b1,1'b0},
    '{16'h0000,16'h0064,16'h0064,16'h0043,16'h0021,16'h0064,16'h0000,1'b1,1'b1}};
  logic clk_sys = 1'b0, rst_n = 1'b0, clk_en = 1'b1, cycle_stb = 1'b0, block_pin = 1'b0;
  logic res_sel = 1'b0;
  logic [15:0] i_l1 = 16'h0000, i_l2 = 16'h0000, i_l3 = 16'h0000, i_pos = 16'h0000;
  logic [15:0] i_neg = 16'h0000, i_calc = 16'h0000, i_meas = 16'h0000;
  logic [19:0] dly = 20'h0_0064;
  logic [3:0] ev_sel = 4'he;
  logic [31:0] ts = 32'h0000_1000;
  logic [3:0] rd_idx = 4'h0;
  logic [2:0] sg = 3'h5;
  logic alarm, blocked, start, ev_valid;
  logic [1:0] ev_code;
  logic [cts_pkg::REC_W-1:0] ev_rec, log_rec;
  logic [3:0] log_cnt;
  int err_total = 0;
  int total_checks = 0;
  int n_ev = 0;
  cts_supervisor dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .cycle_stb(cycle_stb), .block_pin(block_pin), .i_l1(i_l1), .i_l2(i_l2), .i_l3(i_l3),
    .i_res_calc(i_calc), .i_res_meas(i_meas), .i_pos_seq(i_pos), .i_neg_seq(i_neg),
    .upper_phase_current_limit(16'h0078), .lower_phase_current_limit(16'h000a),
    .residual_diff_limit(16'h000a), .min_max_current_ratio_limit(14'h03e8),
    .neg_pos_sequence_ratio_limit(14'h1324), .residual_input_select(res_sel),
    .alarm_delay_cycles(dly), .event_store_sel(ev_sel), .time_stamp(ts),
    .setting_group(sg), .log_rd_idx(rd_idx), .alarm_ff(alarm), .blocked_ff(blocked),
    .start_ff(start), .event_valid_ff(ev_valid), .event_code_ff(ev_code),
    .event_rec_ff(ev_rec), .log_rec_ff(log_rec), .log_count_ff(log_cnt));
  // 125 MHz system clock
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk_bit(input string n, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One program cycle; the gap of one idle clock keeps strobes two apart
  task automatic strobe(input cts_tb_row_t r, input logic en);
    @(posedge clk_sys);
    #1;
    {i_l1, i_l2, i_l3, i_pos, i_neg, i_calc, i_meas, res_sel} = r[113:1];
    clk_en = en;
    cycle_stb = 1'b1;
    ts = ts + 32'h0000_0001;
    @(posedge clk_sys);
    #1;
    cycle_stb = 1'b0;
    clk_en = 1'b1;
  endtask
  // Event seen right after its strobe, log write one clock later
  task automatic chk_ev(input logic [1:0] c, input logic v);
    chk_val("event_code", 32'(c), 32'(ev_code));
    chk_bit("event_valid", v, ev_valid);
    chk_val("rec_stamp", ts, ev_rec[cts_pkg::REC_TS_LSB +: 32]);
    chk_val("rec_code", 32'(c), 32'(ev_rec[cts_pkg::REC_EV_LSB +: 2]));
    chk_val("rec_l2", 32'(i_l2), 32'(ev_rec[31:16]));
    chk_val("rec_group", 32'(sg), 32'(ev_rec[cts_pkg::REC_SG_LSB +: 3]));
    @(posedge clk_sys);
    #1;
    n_ev = (n_ev < 12) ? n_ev + 1 : 12;
    chk_val("log_count", 32'(n_ev), 32'(log_cnt));
  endtask
  task automatic rd_log(input logic [3:0] i, input logic [31:0] e);
    rd_idx = i;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_val("log_stamp", e, log_rec[cts_pkg::REC_TS_LSB +: 32]);
  endtask
  // Hang guard, far above the roughly 120 clocks the run needs
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk_bit("alarm_rst", 1'b0, alarm);
    chk_val("log_count_rst", 32'h0000_0000, 32'(log_cnt));
    // Long delay here, so only the pick-up decision shows
    for (int k = 0; k < 7; k++) begin
      strobe(rows[k], 1'b1);
      chk_bit("start", rows[k].pick, start);
      chk_bit("alarm_table", 1'b0, alarm);
    end
    strobe(rows[0], 1'b1);
    dly = 20'h0_0003;
    // Lost condition at the third strobe restarts the count
    for (int k = 0; k < 6; k++) begin
      strobe((k == 2) ? rows[0] : rows[1], 1'b1);
      chk_bit("alarm_delay", k == 5, alarm);
    end
    chk_ev(2'h1, 1'b1);
    chk_val("rec_fault_on", 32'h0000_001f, 32'(ev_rec[cts_pkg::REC_FLT_LSB +: 5]));
    chk_val("rec_remain", 32'h0000_0001, 32'(ev_rec[cts_pkg::REC_TMR_LSB +: 20]));
    strobe(rows[0], 1'b1);
    chk_bit("alarm_off", 1'b0, alarm);
    chk_ev(2'h0, 1'b0);
    chk_val("rec_fault_off", 32'h0000_0013, 32'(ev_rec[cts_pkg::REC_FLT_LSB +: 5]));
    strobe(rows[1], 1'b0);
    chk_bit("start_frozen", 1'b0, start);
    // Block needs two clocks through the synchroniser
    block_pin = 1'b1;
    repeat (3) @(posedge clk_sys);
    strobe(rows[1], 1'b1);
    chk_bit("blocked_on", 1'b1, blocked);
    chk_bit("start_blocked", 1'b0, start);
    chk_ev(2'h3, 1'b1);
    block_pin = 1'b0;
    repeat (3) @(posedge clk_sys);
    strobe(rows[1], 1'b1);
    chk_bit("blocked_off", 1'b0, blocked);
    chk_bit("start_free", 1'b1, start);
    chk_ev(2'h2, 1'b1);
    // Twelve more events overrun the rolling log
    dly = 20'h0_0001;
    sg = 3'h2;
    for (int k = 0; k < 6; k++) begin
      strobe(rows[1], 1'b1);
      chk_ev(2'h1, 1'b1);
      strobe(rows[0], 1'b1);
      chk_ev(2'h0, 1'b0);
    end
    rd_log(4'h0, ts);
    rd_log(4'hb, ts - 32'h0000_000b);
    rd_log(4'hc, 32'h0000_0000);
    // Alarm drop and block on from one strobe: alarm event first, block a clock later
    strobe(rows[1], 1'b1);
    chk_ev(2'h1, 1'b1);
    block_pin = 1'b1;
    repeat (3) @(posedge clk_sys);
    strobe(rows[1], 1'b1);
    chk_bit("alarm_drop_blk", 1'b0, alarm);
    chk_bit("blocked_pend", 1'b1, blocked);
    chk_ev(2'h0, 1'b0);
    chk_val("pend_code", 32'h0000_0003, 32'(ev_code));
    chk_bit("pend_valid", 1'b1, ev_valid);
    chk_val("pend_stamp", ts, ev_rec[cts_pkg::REC_TS_LSB +: 32]);
    block_pin = 1'b0;
    // Second reset in mid-run clears the log
    rst_n = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    chk_val("log_count_rst2", 32'h0000_0000, 32'(log_cnt));
    chk_bit("alarm_rst2", 1'b0, alarm);
    chk_bit("blocked_rst2", 1'b0, blocked);
    wrap_up();
  end
endmodule
